// [sios_core.sv]
// Purpose: winding pwm, quadrature counter, free digital channels and status indicators
// Assumes: all inputs synchronous to core_clk; srst synchronous, active high
// Notes: the encoder count is only reported, never fed back into stepping
`default_nettype none

module sios_core
	import sios_pkg::*;
#(
	parameter int PWM_CYCLES = PWM_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC,
	parameter int CNT_W = ENC_CNT_W
) (
	input wire logic core_clk, // core clock
	input wire logic srst, // synchronous reset
	input wire logic encoder_mode, // channels one and three used as encoder
	input wire logic enc_clear, // zero the encoder count
	input wire logic step_req, // advance one microstep
	input wire logic step_dir, // 1 forward, 0 backward
	input wire logic [1:0] drive_state, // drive state machine state
	input wire logic overheat, // power stage over temperature
	input wire logic overheat_ack, // release the shutdown once cool
	input wire logic bus_ok, // backplane communication works
	input wire logic module_err, // module status reports an error
	input wire logic signed [15:0] velocity_setpoint, // velocity setpoint
	input wire logic [15:0] status_word, // drive status word
	input wire logic [CH_NUM-1:0] dio_out_val, // user output levels
	input wire logic [CH_NUM-1:0] dio_drive, // user: 1 drives channel as output
	input wire logic [CH_NUM-1:0] ch_in, // channel pin levels
	output logic [CH_NUM-1:0] ch_out, // channel pin drive level
	output logic [CH_NUM-1:0] ch_oe_n, // channel pin enable, low drives
	output logic [CH_NUM-1:0] dio_in, // sampled channel levels for the user
	output logic signed [CNT_W-1:0] enc_count, // accumulated encoder count
	output logic winding_a_out_one, // winding A, connection one
	output logic winding_a_out_two, // winding A, connection two
	output logic winding_b_out_one, // winding B, connection one
	output logic winding_b_out_two, // winding B, connection two
	output logic stage_shutdown, // power stage held off
	output logic [PHASE_W-1:0] ustep_phase, // electrical microstep position
	output logic bus_led, // bus indicator
	output logic module_fault_led, // module fault indicator
	output logic drive_state_led, // power stage indicator
	output logic velocity_setpoint_led, // setpoint indicator
	output logic fault_led, // status word fault indicator
	output logic [CH_NUM-1:0] chan_led // channel indicators
);

	localparam int PWM_W = $clog2(PWM_CYCLES);
	localparam int BLK_W = $clog2(BLINK_CYCLES);

	// half sine over 128 positions by parabola, peak clipped to 8 bits
	function automatic logic [7:0] sios_half_sine(input logic [6:0] x);
		logic [13:0] p;
		p = 14'(x) * (14'd128 - 14'(x));
		sios_half_sine = (p[13:4] > 10'd255) ? 8'hff : p[11:4];
	endfunction

	// pwm compare level for a magnitude
	function automatic logic [PWM_W-1:0] sios_duty(input logic [7:0] mag);
		sios_duty = PWM_W'((32'(mag) * 32'(PWM_CYCLES)) >> 8);
	endfunction

	sios_drv_e drv;
	assign drv = sios_drv_e'(drive_state);

	// channel pins: encoder phases forced to inputs, the rest as the user asks
	logic [CH_NUM-1:0] in_r, in_nxt, prev_r, prev_nxt, out_r, out_nxt, oen_r, oen_nxt;
	logic [1:0] warm_r, warm_nxt;
	always_comb begin
		in_nxt = ch_in;
		prev_nxt = in_r;
		// edge history is trusted only once two real samples follow reset
		warm_nxt = {warm_r[0], 1'b1};
		out_nxt = dio_out_val;
		oen_nxt = ~dio_drive;
		if (encoder_mode) begin
			oen_nxt[CH_ENC_A] = 1'b1;
			oen_nxt[CH_ENC_B] = 1'b1;
			out_nxt[CH_ENC_A] = 1'b0;
			out_nxt[CH_ENC_B] = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			in_r <= '0;
			prev_r <= '0;
			out_r <= '0;
			oen_r <= '1;
			warm_r <= 2'h0;
		end else begin
			warm_r <= warm_nxt;
			in_r <= in_nxt;
			prev_r <= prev_nxt;
			out_r <= out_nxt;
			oen_r <= oen_nxt;
		end
	end

	assign ch_out = out_r;
	assign ch_oe_n = oen_r;
	assign dio_in = in_r;

	// quadrature decode; at 200 MHz a 100 kHz fourfold edge rate leaves hundreds of samples
	logic pa, pb, ca, cb, enc_inc, enc_dec;
	logic signed [CNT_W-1:0] cnt_r, cnt_nxt;
	always_comb begin
		pa = prev_r[CH_ENC_A];
		pb = prev_r[CH_ENC_B];
		ca = in_r[CH_ENC_A];
		cb = in_r[CH_ENC_B];
		// a pin resting high through reset would otherwise look like an edge
		enc_inc = encoder_mode && warm_r[1] && ((ca ^ pa) ^ (cb ^ pb)) && (ca ^ pb);
		enc_dec = encoder_mode && warm_r[1] && ((ca ^ pa) ^ (cb ^ pb)) && !(ca ^ pb);
		cnt_nxt = cnt_r;
		if (enc_clear)
			cnt_nxt = '0;
		else if (enc_inc)
			cnt_nxt = cnt_r + CNT_W'(1);
		else if (enc_dec)
			cnt_nxt = cnt_r - CNT_W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign enc_count = cnt_r;

	// overheat shutdown: held until cool and acknowledged; a fresh overheat wins
	logic shut_r, shut_nxt;
	always_comb begin
		shut_nxt = shut_r;
		if (overheat)
			shut_nxt = 1'b1;
		else if (overheat_ack)
			shut_nxt = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			shut_r <= 1'b0;
		else
			shut_r <= shut_nxt;
	end

	assign stage_shutdown = shut_r;

	// microstep position, moves only while operation is enabled and the stage is on
	logic run;
	logic [PHASE_W-1:0] ph_r, ph_nxt;
	assign run = (drv == SIOS_DRV_OP_ENABLED) && !shut_r && !overheat;
	always_comb begin
		ph_nxt = ph_r;
		if (run && step_req)
			ph_nxt = step_dir ? ph_r + 8'h01 : ph_r - 8'h01;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			ph_r <= '0;
		else
			ph_r <= ph_nxt;
	end

	assign ustep_phase = ph_r;

	// winding pwm: B leads A by a quarter turn; sign picks which side of the bridge switches
	logic [PWM_W-1:0] pwm_r, pwm_nxt;
	logic [PHASE_W-1:0] ph_b;
	logic on_a, on_b;
	logic [3:0] wind_r, wind_nxt;
	always_comb begin
		ph_b = ph_r + QUARTER_TURN;
		pwm_nxt = (pwm_r == PWM_W'(PWM_CYCLES - 1)) ? '0 : pwm_r + PWM_W'(1);
		on_a = pwm_r < sios_duty(sios_half_sine(ph_r[6:0]));
		on_b = pwm_r < sios_duty(sios_half_sine(ph_b[6:0]));
		wind_nxt[0] = on_a && !ph_r[7];
		wind_nxt[1] = on_a && ph_r[7];
		wind_nxt[2] = on_b && !ph_b[7];
		wind_nxt[3] = on_b && ph_b[7];
		// stage off cuts every switch at the clock edge that ends the cycle the fault is seen
		if (!run)
			wind_nxt = 4'h0;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pwm_r <= '0;
			wind_r <= 4'h0;
		end else begin
			pwm_r <= pwm_nxt;
			wind_r <= wind_nxt;
		end
	end

	assign winding_a_out_one = wind_r[0];
	assign winding_a_out_two = wind_r[1];
	assign winding_b_out_one = wind_r[2];
	assign winding_b_out_two = wind_r[3];

	// blink source shared by the power and fault indicators
	logic [BLK_W-1:0] blk_cnt_r, blk_cnt_nxt;
	logic blink_r, blink_nxt;
	always_comb begin
		blk_cnt_nxt = blk_cnt_r + BLK_W'(1);
		blink_nxt = blink_r;
		if (blk_cnt_r == BLK_W'(BLINK_CYCLES - 1)) begin
			blk_cnt_nxt = '0;
			blink_nxt = !blink_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			blk_cnt_r <= '0;
			blink_r <= 1'b0;
		end else begin
			blk_cnt_r <= blk_cnt_nxt;
			blink_r <= blink_nxt;
		end
	end

	// indicators: blinking marks the milder of two lit states
	logic [8:0] led_r, led_nxt;
	always_comb begin
		led_nxt[0] = bus_ok && !module_err;
		led_nxt[1] = module_err || !bus_ok;
		unique case (drv)
			SIOS_DRV_SWITCHED_ON: led_nxt[2] = blink_r;
			SIOS_DRV_OP_ENABLED: led_nxt[2] = 1'b1;
			default: led_nxt[2] = 1'b0;
		endcase
		led_nxt[3] = velocity_setpoint > 16'sh0000;
		if ((status_word & STW_ERR_MASK) != 16'h0000)
			led_nxt[4] = 1'b1;
		else if ((status_word & STW_WARN_MASK) != 16'h0000)
			led_nxt[4] = blink_r;
		else
			led_nxt[4] = 1'b0;
		led_nxt[8:5] = in_r;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			led_r <= '0;
		else
			led_r <= led_nxt;
	end

	assign bus_led = led_r[0];
	assign module_fault_led = led_r[1];
	assign drive_state_led = led_r[2];
	assign velocity_setpoint_led = led_r[3];
	assign fault_led = led_r[4];
	assign chan_led = led_r[8:5];

	enc_inputs_a: assert property (@(posedge core_clk) disable iff (srst)
		encoder_mode |=> ch_oe_n[CH_ENC_A] && ch_oe_n[CH_ENC_B])
		else $error("encoder channel driven in encoder mode");

	enc_count_a: assert property (@(posedge core_clk) disable iff (srst)
		$changed(ch_in[CH_ENC_A]) && $stable(ch_in[CH_ENC_B]) && encoder_mode
		&& $stable(encoder_mode) && !$past(srst) ##1 encoder_mode && !enc_clear
		|=> enc_count != $past(enc_count))
		else $error("single phase edge not counted");

	enc_dir_a: assert property (@(posedge core_clk) disable iff (srst)
		encoder_mode && !enc_clear && !$past(srst, 2) && (ca != pa) && (cb == pb)
		&& (ca != cb) |=> enc_count == $past(enc_count) + CNT_W'(1))
		else $error("forward edge did not count up");

	enc_both_a: assert property (@(posedge core_clk) disable iff (srst)
		(ca ^ pa) && (cb ^ pb) && !enc_clear |=> $stable(enc_count))
		else $error("double change altered the count");

	free_chan_a: assert property (@(posedge core_clk) disable iff (srst)
		dio_drive[CH_FREE_TWO] && dio_drive[CH_FREE_FOUR] |=>
		!ch_oe_n[CH_FREE_TWO] && !ch_oe_n[CH_FREE_FOUR])
		else $error("free channel not driven");

	ustep_a: assert property (@(posedge core_clk) disable iff (srst)
		run && step_req && step_dir |=> ustep_phase == $past(ustep_phase) + 8'h01)
		else $error("microstep did not advance");

	pair_a: assert property (@(posedge core_clk) disable iff (srst)
		!(winding_a_out_one && winding_a_out_two) && !(winding_b_out_one && winding_b_out_two))
		else $error("both sides of a bridge on");

	overheat_a: assert property (@(posedge core_clk) disable iff (srst)
		overheat |=> !winding_a_out_one && !winding_a_out_two && !winding_b_out_one
		&& !winding_b_out_two && stage_shutdown)
		else $error("power stage on while overheated");

	bus_led_a: assert property (@(posedge core_clk) disable iff (srst)
		!bus_ok |=> module_fault_led && !bus_led)
		else $error("bus indicators wrong without communication");

	drive_led_a: assert property (@(posedge core_clk) disable iff (srst)
		drv != SIOS_DRV_SWITCHED_ON && drv != SIOS_DRV_OP_ENABLED |=> !drive_state_led)
		else $error("power indicator lit in other state");

	setpoint_led_a: assert property (@(posedge core_clk) disable iff (srst)
		velocity_setpoint == 16'sh0000 |=> !velocity_setpoint_led)
		else $error("setpoint indicator lit at zero");

	fault_led_a: assert property (@(posedge core_clk) disable iff (srst)
		(status_word & STW_ERR_MASK) != 16'h0000 |=> fault_led)
		else $error("error bit not shown");

	chan_led_a: assert property (@(posedge core_clk) disable iff (srst)
		##1 1'b1 |=> chan_led == $past(ch_in, 2))
		else $error("channel indicator not following pin");

endmodule

`default_nettype wire

// [sios_enc_model.sv]
// Purpose: quadrature encoder and channel pin model facing the stepper i/o logic
// Assumes: phases change just after a rising core_clk edge
// Notes: an undriven free channel shows the level the bench sets on ext_lvl
`default_nettype none

module sios_enc_model
	import sios_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic [CH_NUM-1:0] ch_out, // dut drive level
	input wire logic [CH_NUM-1:0] ch_oe_n, // dut enable, low drives
	input wire logic [CH_NUM-1:0] ext_lvl, // outside level of free channels
	output logic [CH_NUM-1:0] ch_in // resolved pin levels
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph = 2'b00; // phase a, phase b

	// one quadrature edge; two cycles apart, far faster than the ENC_EDGE_CYC spacing of the rate limit
	task automatic move(input logic fwd);
		repeat (2) @(posedge core_clk);
		#1;
		ph = fwd ? {~ph[0], ph[1]} : {ph[0], ~ph[1]};
	endtask

	// both phases at once, an invalid step the decoder must drop
	task automatic jump();
		repeat (2) @(posedge core_clk);
		#1;
		ph = ~ph;
	endtask

	// encoder phases sit on channels one and three unless the dut drives them
	assign ch_in[CH_ENC_A] = ch_oe_n[CH_ENC_A] ? ph[1] : ch_out[CH_ENC_A];
	assign ch_in[CH_ENC_B] = ch_oe_n[CH_ENC_B] ? ph[0] : ch_out[CH_ENC_B];
	assign ch_in[CH_FREE_TWO] = ch_oe_n[CH_FREE_TWO] ? ext_lvl[1] : ch_out[CH_FREE_TWO];
	assign ch_in[CH_FREE_FOUR] = ch_oe_n[CH_FREE_FOUR] ? ext_lvl[3] : ch_out[CH_FREE_FOUR];
endmodule

`default_nettype wire

// [sios_pkg.sv]
// Purpose: shared constants and types for the stepper i/o and status logic
// Assumes: 200 MHz core clock
// Notes: pwm and blink periods are derived from their rates here
`default_nettype none

package sios_pkg;

	// core clock
	localparam int CLK_HZ = 200_000_000;

	// winding pwm carrier
	localparam int PWM_HZ = 32_000;
	localparam int PWM_CYC = CLK_HZ / PWM_HZ;

	// microstep geometry: 64 microsteps per full step, 4 full steps per electrical turn
	localparam int USTEP_PER_FULL = 64;
	localparam int FULL_PER_TURN = 4;
	localparam int PHASE_W = 8;
	localparam logic [7:0] QUARTER_TURN = 8'h40;

	// encoder input limit and the least spacing of decoded edges at that rate
	localparam int ENC_MAX_HZ = 100_000;
	localparam int ENC_EDGE_CYC = CLK_HZ / (ENC_MAX_HZ * 4);
	localparam int ENC_CNT_W = 32;

	// digital channel positions
	localparam int CH_ENC_A = 0;
	localparam int CH_FREE_TWO = 1;
	localparam int CH_ENC_B = 2;
	localparam int CH_FREE_FOUR = 3;
	localparam int CH_NUM = 4;

	// status word bits shown on the fault indicator
	localparam logic [15:0] STW_WARN_MASK = 16'h0080;
	localparam logic [15:0] STW_ERR_MASK = 16'h0008;

	// indicator blink rate, half period in cycles
	localparam int BLINK_HZ = 2;
	localparam int BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);

	// drive state as reported by the drive state machine
	typedef enum logic [1:0] {
		SIOS_DRV_OTHER = 2'b00,
		SIOS_DRV_SWITCHED_ON = 2'b01,
		SIOS_DRV_OP_ENABLED = 2'b11
	} sios_drv_e;

endpackage

`default_nettype wire

// [test_stepper_io_status_logic.sv]
// Purpose: self-checking bench for the stepper i/o and status logic
// Assumes: short pwm and blink periods via parameters
// Notes: indicators are graded dark, blinking or steady over 16 cycles
`default_nettype none

module test_stepper_io_status_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import sios_pkg::*;
	logic core_clk = 1'b0, srst = 1'b1, encoder_mode = 1'b0, enc_clear = 1'b0;
	logic step_req = 1'b0, step_dir = 1'b1, overheat = 1'b0, overheat_ack = 1'b0;
	logic bus_ok = 1'b0, module_err = 1'b0;
	logic [1:0] drive_state = 2'h0;
	logic signed [15:0] velocity_setpoint = 16'sh0000;
	logic [15:0] status_word = 16'h0000;
	logic [CH_NUM-1:0] dio_out_val = 4'h0, dio_drive = 4'h0, ext_lvl = 4'h0;
	wire logic [CH_NUM-1:0] ch_in, ch_out, ch_oe_n, dio_in, chan_led;
	wire logic signed [31:0] enc_count;
	wire logic [3:0] wnd;
	wire logic [4:0] led;
	wire logic stage_shutdown;
	wire logic [7:0] ustep_phase;
	int error_cnt = 0;
	int n_tests = 0;

	sios_core #(.PWM_CYCLES(64), .BLINK_CYCLES(4), .CNT_W(32)) u_dut (
		.core_clk(core_clk), .srst(srst), .encoder_mode(encoder_mode),
		.enc_clear(enc_clear), .step_req(step_req), .step_dir(step_dir),
		.drive_state(drive_state), .overheat(overheat), .overheat_ack(overheat_ack),
		.bus_ok(bus_ok), .module_err(module_err), .velocity_setpoint(velocity_setpoint),
		.status_word(status_word), .dio_out_val(dio_out_val), .dio_drive(dio_drive),
		.ch_in(ch_in), .ch_out(ch_out), .ch_oe_n(ch_oe_n), .dio_in(dio_in),
		.enc_count(enc_count), .winding_a_out_one(wnd[3]), .winding_a_out_two(wnd[2]),
		.winding_b_out_one(wnd[1]), .winding_b_out_two(wnd[0]),
		.stage_shutdown(stage_shutdown), .ustep_phase(ustep_phase), .bus_led(led[4]),
		.module_fault_led(led[3]), .drive_state_led(led[2]),
		.velocity_setpoint_led(led[1]), .fault_led(led[0]), .chan_led(chan_led)
	);

	sios_enc_model u_model (
		.core_clk(core_clk), .ch_out(ch_out), .ch_oe_n(ch_oe_n), .ext_lvl(ext_lvl),
		.ch_in(ch_in)
	);

	// 200 MHz core clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// grade one indicator: 0 dark, 1 blinking, 2 steady
	task automatic grade(input int k, output int g);
		int n;
		n = 0;
		tick(3);
		repeat (16) begin
			tick(1);
			n += led[k];
		end
		g = (n == 0) ? 0 : (n == 16) ? 2 : 1;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// a full step forward, pwm routing, overheat refusal, then back again
	task automatic t_step();
		int a1, rest;
		drive_state = 2'h3;
		step_req = 1'b1;
		tick(64);
		step_req = 1'b0;
		tick(2);
		chk(ustep_phase, 8'h40);
		a1 = 0;
		rest = 0;
		repeat (128) begin
			tick(1);
			a1 += wnd[3];
			rest += wnd[2] + wnd[1] + wnd[0];
		end
		chk(a1 > 0, 1);
		chk(rest, 0);
		// overheat and acknowledge together: the fault must win
		overheat = 1'b1;
		overheat_ack = 1'b1;
		step_req = 1'b1;
		tick(3);
		chk(stage_shutdown, 1);
		chk(wnd, 0);
		chk(ustep_phase, 8'h40);
		step_req = 1'b0;
		overheat = 1'b0;
		tick(2);
		overheat_ack = 1'b0;
		chk(stage_shutdown, 0);
		step_dir = 1'b0;
		step_req = 1'b1;
		tick(64);
		step_req = 1'b0;
		tick(2);
		chk(ustep_phase, 8'h00);
		// at phase zero only winding B, connection one, may switch
		a1 = 0;
		rest = 0;
		repeat (128) begin
			tick(1);
			a1 += wnd[1];
			rest += wnd[3] + wnd[2] + wnd[0];
		end
		chk(a1 > 0, 1);
		chk(rest, 0);
	endtask

	// encoder on channels one and three while two and four stay outputs
	task automatic t_enc();
		encoder_mode = 1'b1;
		dio_drive = 4'hf;
		dio_out_val = 4'hf;
		tick(2);
		chk(ch_oe_n, 4'h5);
		chk(ch_out, 4'ha);
		repeat (8) u_model.move(1'b1);
		tick(4);
		chk(enc_count, 8);
		repeat (3) u_model.move(1'b0);
		u_model.jump();
		tick(4);
		chk(enc_count, 5);
		chk(ustep_phase, 8'h00);
		enc_clear = 1'b1;
		tick(1);
		enc_clear = 1'b0;
		encoder_mode = 1'b0;
		dio_drive = 4'h0;
		u_model.move(1'b1);
		tick(4);
		chk(enc_count, 0);
	endtask

	// reset in mid-run while phase A rests high: no false edge may follow
	task automatic t_reset();
		encoder_mode = 1'b1;
		drive_state = 2'h3;
		step_dir = 1'b1;
		step_req = 1'b1;
		bus_ok = 1'b1;
		u_model.move(1'b1);
		tick(4);
		chk(enc_count, 1);
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		step_req = 1'b0;
		chk(enc_count, 0);
		chk(ustep_phase, 8'h00);
		chk(led[4], 0);
		tick(4);
		chk(enc_count, 0);
		u_model.move(1'b1);
		tick(4);
		chk(enc_count, 1);
		encoder_mode = 1'b0;
	endtask

	// status indicators against their sources
	task automatic t_led();
		int g;
		int ds[4] = '{0, 1, 0, 2};
		logic [15:0] sp[3] = '{16'h0000, 16'h0005, 16'hfffb};
		int spx[3] = '{0, 2, 0};
		logic [15:0] sw[4] = '{16'h0000, 16'h0080, 16'h0008, 16'h0088};
		int swx[4] = '{0, 1, 2, 2};
		for (int i = 0; i < 4; i++) begin
			bus_ok = i[1];
			module_err = i[0];
			tick(3);
			chk(led[4], bus_ok && !module_err);
			chk(led[3], module_err || !bus_ok);
			drive_state = i[1:0];
			grade(2, g);
			chk(g, ds[i]);
			status_word = sw[i];
			grade(0, g);
			chk(g, swx[i]);
		end
		for (int i = 0; i < 3; i++) begin
			velocity_setpoint = sp[i];
			grade(1, g);
			chk(g, spx[i]);
		end
		for (int i = 0; i < 2; i++) begin
			dio_drive = 4'h2;
			dio_out_val = i[0] ? 4'h2 : 4'h0;
			ext_lvl = i[0] ? 4'h0 : 4'h8;
			tick(4);
			// phases rest at both high after the reset scenario
			chk(chan_led, i[0] ? 4'h7 : 4'hd);
			chk(dio_in, i[0] ? 4'h7 : 4'hd);
			chk(ch_oe_n, 4'hd);
		end
	endtask

	// main sequence
	initial begin
		tick(16);
		srst = 1'b0;
		chk(ch_oe_n, 4'hf);
		chk(ustep_phase, 8'h00);
		t_step();
		t_enc();
		t_reset();
		t_led();
		wrap_up();
	end

	// watchdog against a hang
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule

`default_nettype wire
